// ### src/flash_array_command_front_end.sv
/*
  command front end of a 256 Kbyte two-block nonvolatile memory with behavioural array.
  assumes reads and command strobes come from logic on clk, so no synchronisers.
*/
`timescale 1ns/100ps

module flash_array_command_front_end
(
  input wire logic clk,
  input wire logic rst,
  input wire logic rd_req,
  input wire logic [17:0] rd_addr,
  input wire logic rd_byte,
  output logic rd_ready,
  output logic rd_valid,
  output logic rd_refused,
  output logic [15:0] rd_data,
  input wire logic cfg_wr,
  input wire logic bank_select_bit,
  input wire logic [1:0] cfg_int_en,
  input wire logic data_wr,
  input wire logic [17:0] data_addr,
  input wire logic [15:0] data_word,
  input wire logic cmd_wr,
  input wire logic [2:0] cmd_code,
  input wire logic launch_wr,
  input wire logic abort_req,
  output logic seq_error,
  output logic [1:0] block_busy,
  output logic bank_sel_q,
  output logic verify_pass,
  output logic [15:0] signature,
  output logic cmd_complete,
  output logic buf_empty,
  output logic irq_complete,
  output logic irq_buf_empty
);
  // ************************************************************
  // storage: two blocks kept as one word array
  // ************************************************************
  localparam int unsigned words = (flash_front_pkg::block_count * flash_front_pkg::block_bytes) / 2;
  // blank as delivered; no reset, since cells keep their data across rst
  logic [15:0] mem [words] = '{default: flash_front_pkg::erased_word};

  // common register: int enables and bank select
  logic bank_r, bank_nxt;
  logic [1:0] ien_r, ien_nxt;

  // three-step command sequence
  flash_front_pkg::seq_state_e seq_r, seq_nxt;
  logic [17:0] s1_addr_r, s1_addr_nxt;
  logic [15:0] s1_data_r, s1_data_nxt;
  logic [2:0] s1_cmd_r, s1_cmd_nxt;
  logic s1_full_r, s1_full_nxt;
  logic err_r, err_nxt;

  // execution stage
  flash_front_pkg::exec_state_e ex_r, ex_nxt;
  logic [17:0] ex_addr_r, ex_addr_nxt;
  logic [15:0] ex_data_r, ex_data_nxt;
  logic [2:0] ex_cmd_r, ex_cmd_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [16:0] scan_r, scan_nxt;
  logic pass_r, pass_nxt;
  logic [15:0] sig_r, sig_nxt;

  // read path
  logic rd_pend_r, rd_pend_nxt;
  logic [17:0] rd_addr_r, rd_addr_nxt;
  logic [7:0] rd_lo_r, rd_lo_nxt;
  logic rd_valid_r, rd_valid_nxt;
  logic rd_ref_r, rd_ref_nxt;
  logic [15:0] rd_data_r, rd_data_nxt;

  logic ex_idle;
  logic take;
  logic wr_prog, wr_erase;
  logic [16:0] wr_lo, wr_hi;
  logic [15:0] cur_word;
  logic [1:0] busy;

  assign ex_idle = (ex_r == flash_front_pkg::st_idle);
  assign take = s1_full_r && ex_idle;
  assign cur_word = mem[scan_r];

  // ************************************************************
  // busy blocks
  // ************************************************************
  always_comb
  begin
    busy = 2'b00;
    if (ex_r == flash_front_pkg::st_run)
    begin
      if (ex_cmd_r == flash_front_pkg::cmd_block_erase || ex_cmd_r == flash_front_pkg::cmd_sector_erase ||
          ex_cmd_r == flash_front_pkg::cmd_program)
      begin
        busy[ex_addr_r[flash_front_pkg::block_bit]] = 1'b1;
      end
    end
  end

  // ************************************************************
  // control: config, sequence, pipeline, execution
  // ************************************************************
  always_comb
  begin
    bank_nxt = bank_r;
    ien_nxt = ien_r;
    seq_nxt = seq_r;
    s1_addr_nxt = s1_addr_r;
    s1_data_nxt = s1_data_r;
    s1_cmd_nxt = s1_cmd_r;
    s1_full_nxt = s1_full_r;
    err_nxt = err_r;
    ex_nxt = ex_r;
    ex_addr_nxt = ex_addr_r;
    ex_data_nxt = ex_data_r;
    ex_cmd_nxt = ex_cmd_r;
    cnt_nxt = cnt_r;
    scan_nxt = scan_r;
    pass_nxt = pass_r;
    sig_nxt = sig_r;
    wr_prog = 1'b0;
    wr_erase = 1'b0;
    wr_lo = '0;
    wr_hi = '0;
    if (cfg_wr)
    begin
      bank_nxt = bank_select_bit;
      ien_nxt = cfg_int_en;
    end
    // stage one frees as stage two takes, so a queued program follows
    if (take)
    begin
      s1_full_nxt = 1'b0;
      ex_addr_nxt = s1_addr_r;
      ex_data_nxt = s1_data_r;
      ex_cmd_nxt = s1_cmd_r;
      scan_nxt = '0;
      pass_nxt = 1'b1;
      sig_nxt = flash_front_pkg::compress_sig_reset;
      case (s1_cmd_r)
        flash_front_pkg::cmd_program: begin ex_nxt = flash_front_pkg::st_run; cnt_nxt = flash_front_pkg::program_cycles; end
        flash_front_pkg::cmd_sector_erase: begin ex_nxt = flash_front_pkg::st_run; cnt_nxt = flash_front_pkg::sector_erase_cycles; end
        flash_front_pkg::cmd_block_erase: begin ex_nxt = flash_front_pkg::st_run; cnt_nxt = flash_front_pkg::block_erase_cycles; end
        flash_front_pkg::cmd_erase_verify: ex_nxt = flash_front_pkg::st_verify;
        default: ex_nxt = flash_front_pkg::st_compress;
      endcase
    end
    // sequence: data write, command write, launch
    case (seq_r)
      flash_front_pkg::seq_wait_data:
      begin
        if (data_wr && !s1_full_r)
        begin
          s1_addr_nxt = bank_r ? {1'b1, data_addr[16:0]} : {1'b0, data_addr[16:0]};
          s1_data_nxt = data_word;
          seq_nxt = flash_front_pkg::seq_wait_cmd;
        end
        else if (cmd_wr || launch_wr || (data_wr && s1_full_r))
        begin
          err_nxt = 1'b1;
        end
      end
      flash_front_pkg::seq_wait_cmd:
      begin
        if (cmd_wr && cmd_code >= flash_front_pkg::cmd_program && cmd_code <= flash_front_pkg::cmd_compress)
        begin
          s1_cmd_nxt = cmd_code;
          seq_nxt = flash_front_pkg::seq_wait_launch;
        end
        else if (cmd_wr || data_wr || launch_wr)
        begin
          err_nxt = 1'b1;
          seq_nxt = flash_front_pkg::seq_wait_data;
        end
      end
      flash_front_pkg::seq_wait_launch:
      begin
        if (launch_wr)
        begin
          s1_full_nxt = 1'b1;
          err_nxt = 1'b0;
          seq_nxt = flash_front_pkg::seq_wait_data;
        end
        else if (cmd_wr || data_wr)
        begin
          err_nxt = 1'b1;
          seq_nxt = flash_front_pkg::seq_wait_data;
        end
      end
      default: seq_nxt = flash_front_pkg::seq_wait_data;
    endcase
    case (ex_r)
      flash_front_pkg::st_run:
      begin
        if (abort_req && ex_cmd_r == flash_front_pkg::cmd_sector_erase)
        begin
          ex_nxt = flash_front_pkg::st_done; // sector left unerased, software repeats
        end
        else if (cnt_r == 16'h0001)
        begin
          ex_nxt = flash_front_pkg::st_done;
          wr_prog = (ex_cmd_r == flash_front_pkg::cmd_program);
          wr_erase = !wr_prog;
          wr_lo = (ex_cmd_r == flash_front_pkg::cmd_block_erase) ? {ex_addr_r[17], 16'h0000} :
                  {ex_addr_r[17:10], 9'h000};
          wr_hi = (ex_cmd_r == flash_front_pkg::cmd_block_erase) ? {ex_addr_r[17], 16'hffff} :
                  {ex_addr_r[17:10], 9'h1ff};
        end
        else
        begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
      flash_front_pkg::st_verify, flash_front_pkg::st_compress:
      begin
        // one word per cycle across the chosen block; limitation: block-sized scan is slow
        if (ex_r == flash_front_pkg::st_verify)
        begin
          pass_nxt = pass_r && (cur_word == flash_front_pkg::erased_word);
        end
        else
        begin
          sig_nxt = {sig_r[14:0], sig_r[15] ^ sig_r[4] ^ sig_r[3] ^ sig_r[1]} ^ cur_word;
        end
        if (scan_r[15:0] == 16'hffff)
        begin
          ex_nxt = flash_front_pkg::st_done;
        end
        scan_nxt = {scan_r[16], scan_r[15:0] + 16'h0001};
      end
      flash_front_pkg::st_done: ex_nxt = flash_front_pkg::st_idle;
      default: ;
    endcase
    if (take && (s1_cmd_r == flash_front_pkg::cmd_erase_verify || s1_cmd_r == flash_front_pkg::cmd_compress))
    begin
      scan_nxt = {s1_addr_r[17], 16'h0000};
    end
    if (rst)
    begin
      bank_nxt = 1'b0;
      ien_nxt = 2'b00;
      seq_nxt = flash_front_pkg::seq_wait_data;
      s1_full_nxt = 1'b0;
      err_nxt = 1'b0;
      ex_nxt = flash_front_pkg::st_idle;
      cnt_nxt = '0;
      pass_nxt = 1'b0;
      sig_nxt = flash_front_pkg::compress_sig_reset;
      wr_prog = 1'b0;
      wr_erase = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    bank_r <= bank_nxt;
    ien_r <= ien_nxt;
    seq_r <= seq_nxt;
    s1_addr_r <= s1_addr_nxt;
    s1_data_r <= s1_data_nxt;
    s1_cmd_r <= s1_cmd_nxt;
    s1_full_r <= s1_full_nxt;
    err_r <= err_nxt;
    ex_r <= ex_nxt;
    ex_addr_r <= ex_addr_nxt;
    ex_data_r <= ex_data_nxt;
    ex_cmd_r <= ex_cmd_nxt;
    cnt_r <= cnt_nxt;
    scan_r <= scan_nxt;
    pass_r <= pass_nxt;
    sig_r <= sig_nxt;
  end

  // ************************************************************
  // array update: program only clears bits, erase sets all
  // ************************************************************
  // the range walk runs only on the single erase cycle, not on every clock
  always_ff @(posedge clk)
  begin
    if (wr_erase)
    begin
      for (int i = 0; i < words; i++)
      begin
        if (17'(i) >= wr_lo && 17'(i) <= wr_hi)
        begin
          mem[i] <= flash_front_pkg::erased_word;
        end
      end
    end
    else if (wr_prog)
    begin
      mem[ex_addr_r[17:1]] <= mem[ex_addr_r[17:1]] & ex_data_r; // relies on prior erase
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  logic [16:0] rd_w0, rd_w1;
  logic rd_blk;
  assign rd_w0 = rd_addr[17:1];
  assign rd_w1 = rd_addr_r[17:1] + 17'h00001;
  assign rd_blk = rd_pend_r ? rd_w1[16] : rd_addr[17];
  assign rd_ready = !rd_pend_r;

  always_comb
  begin
    rd_pend_nxt = 1'b0;
    rd_addr_nxt = rd_addr_r;
    rd_lo_nxt = rd_lo_r;
    rd_valid_nxt = 1'b0;
    rd_ref_nxt = 1'b0;
    rd_data_nxt = rd_data_r;
    if (rd_pend_r)
    begin
      if (busy[rd_blk])
      begin
        rd_ref_nxt = 1'b1;
      end
      else
      begin
        rd_valid_nxt = 1'b1;
        rd_data_nxt = {rd_lo_r, mem[rd_w1][15:8]}; // second cycle of misaligned word
      end
    end
    else if (rd_req)
    begin
      if (busy[rd_blk])
      begin
        rd_ref_nxt = 1'b1;
      end
      else if (rd_byte)
      begin
        rd_valid_nxt = 1'b1;
        rd_data_nxt = {8'h00, rd_addr[0] ? mem[rd_w0][7:0] : mem[rd_w0][15:8]};
      end
      else if (!rd_addr[0])
      begin
        rd_valid_nxt = 1'b1;
        rd_data_nxt = mem[rd_w0];
      end
      else
      begin
        rd_pend_nxt = 1'b1;
        rd_addr_nxt = rd_addr;
        rd_lo_nxt = mem[rd_w0][7:0];
      end
    end
    if (rst)
    begin
      rd_pend_nxt = 1'b0;
      rd_valid_nxt = 1'b0;
      rd_ref_nxt = 1'b0;
      rd_data_nxt = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    rd_pend_r <= rd_pend_nxt;
    rd_addr_r <= rd_addr_nxt;
    rd_lo_r <= rd_lo_nxt;
    rd_valid_r <= rd_valid_nxt;
    rd_ref_r <= rd_ref_nxt;
    rd_data_r <= rd_data_nxt;
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign rd_valid = rd_valid_r;
  assign rd_refused = rd_ref_r;
  assign rd_data = rd_data_r;
  assign seq_error = err_r;
  assign block_busy = busy;
  assign bank_sel_q = bank_r;
  assign verify_pass = pass_r;
  assign signature = sig_r;
  assign cmd_complete = ex_idle && !s1_full_r;
  assign buf_empty = !s1_full_r;
  assign irq_complete = ien_r[0] && cmd_complete;
  assign irq_buf_empty = ien_r[1] && buf_empty;
endmodule

// ### src/flash_front_pkg.sv
/*
  constants for the nonvolatile program memory command front end.
  assumes a 16-bit processor bus, byte addressed, one clock domain.
*/
package flash_front_pkg;
  // ************************************************************
  // array geometry
  // ************************************************************
  localparam int unsigned block_count = 2;
  localparam int unsigned block_bytes = 131072;
  localparam int unsigned sector_bytes = 1024;
  localparam int unsigned sectors_per_block = 128;
  localparam int unsigned addr_w = 18;
  localparam int unsigned block_addr_w = 17;
  localparam int unsigned sector_w = 7;
  localparam int unsigned block_bit = 17;
  localparam int unsigned sector_lsb = 10;
  localparam int unsigned word_w = 16;
  localparam int unsigned byte_w = 8;
  // ************************************************************
  // cell levels and command codes
  // ************************************************************
  localparam logic [15:0] erased_word = 16'hffff;
  localparam logic [7:0] erased_byte = 8'hff;
  localparam logic [2:0] cmd_program = 3'h1;
  localparam logic [2:0] cmd_sector_erase = 3'h2;
  localparam logic [2:0] cmd_block_erase = 3'h3;
  localparam logic [2:0] cmd_erase_verify = 3'h4;
  localparam logic [2:0] cmd_compress = 3'h5;
  // ************************************************************
  // timing counts in bus clocks and signature reset value
  // ************************************************************
  localparam logic [15:0] program_cycles = 16'h0010;
  localparam logic [15:0] sector_erase_cycles = 16'h0400;
  localparam logic [15:0] block_erase_cycles = 16'h1000;
  localparam logic [15:0] compress_sig_reset = 16'h0000;

  typedef enum logic [2:0]
  {
    st_idle = 3'b000,
    st_run = 3'b001,
    st_verify = 3'b010,
    st_compress = 3'b011,
    st_done = 3'b100
  } exec_state_e;

  typedef enum logic [1:0]
  {
    seq_wait_data = 2'b00,
    seq_wait_cmd = 2'b01,
    seq_wait_launch = 2'b10
  } seq_state_e;
endpackage

// ### verification/flash_front_chk.sv
/*
  property checker for the memory command front end, bound to its top module.
  assumes one clock domain with synchronous active high reset.
*/
`timescale 1ns/100ps
module flash_front_chk
(
  input wire logic clk,
  input wire logic rst,
  input wire logic rd_req,
  input wire logic [17:0] rd_addr,
  input wire logic rd_byte,
  input wire logic rd_ready,
  input wire logic rd_valid,
  input wire logic rd_refused,
  input wire logic cfg_wr,
  input wire logic bank_select_bit,
  input wire logic [1:0] cfg_int_en,
  input wire logic data_wr,
  input wire logic cmd_wr,
  input wire logic [2:0] cmd_code,
  input wire logic launch_wr,
  input wire logic seq_error,
  input wire logic [1:0] block_busy,
  input wire logic bank_sel_q,
  input wire logic cmd_complete,
  input wire logic buf_empty,
  input wire logic irq_complete,
  input wire logic irq_buf_empty
);
  logic [1:0] int_en_r;
  logic [1:0] int_en_nxt;
  // ****************
  // enable shadow
  // ****************
  // the enables are not visible at the ports, so they are tracked here
  always_comb
  begin
    int_en_nxt = int_en_r;
    if (cfg_wr)
      int_en_nxt = cfg_int_en;
  end
  always_ff @(posedge clk)
  begin
    int_en_r <= rst ? 2'h0 : int_en_nxt;
  end
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  chk_read_one: assert property (rd_req && rd_ready && (rd_byte || !rd_addr[0]) |=> rd_valid != rd_refused)
    else $error("short read not answered in one cycle");
  chk_read_split: assert property (rd_req && rd_ready && !rd_byte && rd_addr[0]
    |=> rd_refused or (!rd_ready && !rd_valid ##1 (rd_valid || rd_refused)))
    else $error("misaligned read not answered in two cycles");
  chk_busy_refuse: assert property (rd_req && rd_ready && (rd_byte || !rd_addr[0])
    && block_busy[rd_addr[17]] |=> rd_refused && !rd_valid)
    else $error("read of busy block not refused");
  chk_done_idle: assert property (cmd_complete |-> block_busy == 2'h0)
    else $error("complete while a block is busy");
  chk_irq_done: assert property (irq_complete == (int_en_r[0] && cmd_complete))
    else $error("completion interrupt wrong");
  chk_irq_empty: assert property (irq_buf_empty == (int_en_r[1] && buf_empty))
    else $error("buffer empty interrupt wrong");
  chk_bank_follow: assert property (cfg_wr |=> bank_sel_q == $past(bank_select_bit))
    else $error("bank select not taken");
  chk_bad_code: assert property (cmd_wr && (cmd_code == 3'h0 || cmd_code > 3'h5) |-> ##[1:2] seq_error)
    else $error("undefined code not flagged");
  chk_launch_walk: assert property (data_wr ##1 cmd_wr && cmd_code == 3'h1 ##1 launch_wr && cmd_complete
    |=> !buf_empty && !cmd_complete ##1 buf_empty && block_busy != 2'h0)
    else $error("launched program not passed to execution");
endmodule
bind flash_array_command_front_end flash_front_chk chk_u (.*);

// ### verification/cpu_bus_model.sv
/*
  processor side model: reads, config writes and three step command sequences.
  assumes the bench calls its tasks one at a time on clk.
*/
`timescale 1ns/100ps
module cpu_bus_model
(
  input wire logic clk,
  input wire logic rd_ready,
  input wire logic rd_valid,
  input wire logic rd_refused,
  input wire logic [15:0] rd_data,
  input wire logic buf_empty,
  output logic rd_req,
  output logic [17:0] rd_addr,
  output logic rd_byte,
  output logic cfg_wr,
  output logic bank_select_bit,
  output logic [1:0] cfg_int_en,
  output logic data_wr,
  output logic [17:0] data_addr,
  output logic [15:0] data_word,
  output logic cmd_wr,
  output logic [2:0] cmd_code,
  output logic launch_wr,
  output logic abort_req
);
  initial
  begin
    {rd_req, rd_addr, rd_byte, cfg_wr, bank_select_bit, cfg_int_en} = '0;
    {data_wr, data_addr, data_word, cmd_wr, cmd_code, launch_wr, abort_req} = '0;
  end
  task automatic cfg(input logic bank, input logic [1:0] en);
    @(posedge clk);
    cfg_wr <= 1'h1;
    bank_select_bit <= bank;
    cfg_int_en <= en;
    @(posedge clk);
    cfg_wr <= 1'h0;
  endtask
  task automatic set_abort(input logic v);
    @(posedge clk);
    abort_req <= v;
  endtask
  // data, command, launch in order, after waiting up to 64 clocks for a free buffer
  // callers program erased words only, once each
  task automatic cmd(input logic [17:0] a, input logic [15:0] d, input logic [2:0] c, input logic skip);
    int n;
    n = 0;
    @(posedge clk);
    while (buf_empty !== 1'h1 && n < 64)
    begin
      @(posedge clk);
      n++;
    end
    if (!skip)
    begin
      data_wr <= 1'h1;
      data_addr <= a;
      data_word <= d;
      @(posedge clk);
      data_wr <= 1'h0;
      // released lines must not keep looking valid
      data_addr <= ~a;
      data_word <= ~d;
    end
    cmd_wr <= 1'h1;
    cmd_code <= c;
    @(posedge clk);
    cmd_wr <= 1'h0;
    launch_wr <= 1'h1;
    @(posedge clk);
    launch_wr <= 1'h0;
  endtask
  task automatic read(input logic [17:0] a, input logic b, output logic [15:0] d, output logic r, output int lat);
    int n;
    n = 0;
    @(posedge clk);
    rd_req <= 1'h1;
    rd_addr <= a;
    rd_byte <= b;
    @(posedge clk);
    while (rd_ready !== 1'h1 && n < 8)
    begin
      @(posedge clk);
      n++;
    end
    rd_req <= 1'h0;
    rd_addr <= ~a;
    lat = 0;
    do
    begin
      @(posedge clk);
      lat++;
    end
    while (rd_valid !== 1'h1 && rd_refused !== 1'h1 && lat < 8);
    d = rd_data;
    r = rd_refused;
  endtask
endmodule

// ### verification/testbench.sv
/*
  self-checking bench for the memory command front end.
  assumes the processor model drives every input but clock and reset.
*/
`timescale 1ns/100ps
module testbench;
  logic clk;
  logic rst;
  logic rd_req, rd_byte, rd_ready, rd_valid, rd_refused, cfg_wr, bank_select_bit, data_wr, cmd_wr, launch_wr;
  logic abort_req, seq_error, bank_sel_q, verify_pass, cmd_complete, buf_empty, irq_complete, irq_buf_empty;
  logic [17:0] rd_addr, data_addr;
  logic [15:0] rd_data, data_word, signature;
  logic [1:0] cfg_int_en, block_busy;
  logic [2:0] cmd_code;
  int num_errors;
  int cmp_count;
  flash_array_command_front_end dut_u (.*);
  cpu_bus_model cpu_u (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic rd(input logic [17:0] a, input logic b, input logic [15:0] e, input int lat, input logic refd);
    logic [15:0] d;
    logic r;
    int l;
    cpu_u.read(a, b, d, r, l);
    check(r, refd, "refusal");
    check(l, lat, "latency");
    if (!refd)
      check(d, e, "read data");
  endtask
  task automatic idle(input int lim);
    int n;
    n = 0;
    @(posedge clk);
    while (cmd_complete !== 1'h1 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    check(n < lim, 1'h1, "command never completed");
  endtask
  task automatic t_reset;
    check({buf_empty, cmd_complete, irq_complete, irq_buf_empty, seq_error, block_busy}, 7'h60, "reset");
    check({verify_pass, signature}, {1'h0, flash_front_pkg::compress_sig_reset}, "result reset");
    rd(18'h0_0000, 1'h0, 16'hffff, 1, 1'h0);
    rd(18'h0_0001, 1'h1, 16'h00ff, 1, 1'h0);
  endtask
  task automatic t_program;
    cpu_u.cfg(1'h0, 2'h1);
    cpu_u.cmd(18'h0_0100, 16'h5a3c, flash_front_pkg::cmd_program, 1'h0);
    rd(18'h0_0100, 1'h0, 16'hffff, 1, 1'h1);
    rd(18'h2_0100, 1'h0, 16'hffff, 1, 1'h0);
    idle(64);
    check(irq_complete, 1'h1, "completion interrupt");
    rd(18'h0_0100, 1'h0, 16'h5a3c, 1, 1'h0);
    rd(18'h0_0101, 1'h1, 16'h003c, 1, 1'h0);
    rd(18'h0_0101, 1'h0, 16'h3cff, 2, 1'h0);
  endtask
  task automatic t_bank;
    cpu_u.cfg(1'h1, 2'h2);
    @(posedge clk);
    check({bank_sel_q, irq_buf_empty, irq_complete}, 3'h6, "bank and enables");
    cpu_u.cmd(18'h0_0100, 16'h1234, flash_front_pkg::cmd_program, 1'h0);
    idle(64);
    rd(18'h2_0100, 1'h0, 16'h1234, 1, 1'h0);
    rd(18'h0_0100, 1'h0, 16'h5a3c, 1, 1'h0);
  endtask
  task automatic t_pipe;
    cpu_u.cfg(1'h0, 2'h3);
    cpu_u.cmd(18'h0_0400, 16'ha5f0, flash_front_pkg::cmd_program, 1'h0);
    cpu_u.cmd(18'h0_0402, 16'h0f0f, flash_front_pkg::cmd_program, 1'h0);
    @(posedge clk);
    check({buf_empty, cmd_complete, irq_buf_empty, seq_error}, 4'h0, "second command queued");
    idle(128);
    rd(18'h0_0400, 1'h0, 16'ha5f0, 1, 1'h0);
    rd(18'h0_0402, 1'h0, 16'h0f0f, 1, 1'h0);
  endtask
  task automatic t_seq;
    cpu_u.cmd(18'h0_0600, 16'h0000, flash_front_pkg::cmd_program, 1'h1);
    @(posedge clk);
    check(seq_error, 1'h1, "launch without data");
    cpu_u.cmd(18'h0_0600, 16'h0000, 3'h7, 1'h0);
    @(posedge clk);
    check({seq_error, block_busy}, 3'h4, "undefined code");
    cpu_u.cmd(18'h0_0600, 16'hc3c3, flash_front_pkg::cmd_program, 1'h0);
    idle(64);
    check(seq_error, 1'h0, "error not cleared");
    rd(18'h0_0600, 1'h0, 16'hc3c3, 1, 1'h0);
  endtask
  task automatic t_erase;
    cpu_u.cmd(18'h0_0100, 16'h0000, flash_front_pkg::cmd_sector_erase, 1'h0);
    repeat (20) @(posedge clk);
    cpu_u.set_abort(1'h1);
    idle(64);
    cpu_u.set_abort(1'h0);
    rd(18'h0_0100, 1'h0, 16'h5a3c, 1, 1'h0);
    cpu_u.cmd(18'h0_0100, 16'h0000, flash_front_pkg::cmd_sector_erase, 1'h0);
    idle(1200);
    rd(18'h0_0100, 1'h0, 16'hffff, 1, 1'h0);
    rd(18'h0_0400, 1'h0, 16'ha5f0, 1, 1'h0);
  endtask
  task automatic t_block;
    cpu_u.cfg(1'h1, 2'h0);
    cpu_u.cmd(18'h0_0000, 16'h0000, flash_front_pkg::cmd_block_erase, 1'h0);
    idle(4500);
    rd(18'h2_0100, 1'h0, 16'hffff, 1, 1'h0);
    rd(18'h0_0400, 1'h0, 16'ha5f0, 1, 1'h0);
    cpu_u.cmd(18'h0_0000, 16'h0000, flash_front_pkg::cmd_erase_verify, 1'h0);
    idle(67000);
    check(verify_pass, 1'h1, "blank block verify");
  endtask
  // full scan is too long to wait for, so a reset cuts it short
  task automatic t_compress;
    cpu_u.cmd(18'h0_0000, 16'h0000, flash_front_pkg::cmd_compress, 1'h0);
    repeat (8) @(posedge clk);
    check(cmd_complete, 1'h0, "compress running");
    check(signature !== flash_front_pkg::compress_sig_reset, 1'h1, "signature not accumulating");
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_reset();
  endtask
  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    num_errors = 0;
    cmp_count = 0;
    rst = 1'h1;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    t_reset();
    t_program();
    t_bank();
    t_pipe();
    t_seq();
    t_erase();
    t_block();
    t_compress();
    tally_and_finish();
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    num_errors++;
    tally_and_finish();
  end
endmodule
